// >>> rtl/iwm_pkg.sv
/*
 Shared constants and types of the two-wire write master.
 Assumes a 10 MHz system clock and a register port with 8-bit byte addresses.
*/
package iwm_pkg;
   // clock and bus timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int SLOW_THRESH_HZ = 4_000_000;
   localparam int FAST_QUARTER_NS = 625; // quarter of a 400 kHz period
   localparam int SLOW_QUARTER_NS = 2500; // quarter of a 100 kHz period
   localparam logic [4:0] FAST_QUARTER_CYC = 5'((FAST_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] SLOW_QUARTER_CYC = 5'((SLOW_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic SLOW_ALLOWED = (SYS_CLK_HZ > SLOW_THRESH_HZ);
   // register offsets
   localparam logic [7:0] REG_CTRL_BYTE = 8'h00;
   localparam logic [7:0] REG_TARGET_ADDR = 8'h04;
   localparam logic [7:0] REG_CONFIG = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0C;
   localparam logic [7:0] REG_COMMAND = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_ACK_FLAG = 8'h18;
   // field positions
   localparam int CFG_SLOW_BIT = 0;
   localparam int CFG_AMODE_LSB = 1;
   localparam int DATA_WORD_BIT = 16;
   localparam int CMD_FULL_BIT = 0;
   localparam int CMD_SINGLE_BIT = 1;
   localparam int CMD_START_BIT = 2;
   localparam int CMD_RESTART_BIT = 3;
   localparam int CMD_STOP_BIT = 4;
   localparam int CMD_ACK_BIT = 5;
   localparam int CMD_READ_BIT = 6;
   localparam int CMD_ARG_LSB = 8;
   localparam int ST_OVF_BIT = 4;
   // reset values and encodings
   localparam logic [7:0] CTRL_BYTE_RST = 8'h00;
   localparam logic [15:0] TARGET_ADDR_RST = 16'h0000;
   localparam logic [1:0] AMODE_NONE = 2'h0;
   localparam logic [1:0] AMODE_BYTE = 2'h1;
   localparam logic [1:0] AMODE_WORD = 2'h2;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   // data queue shape and default pins
   localparam int FIFO_WIDTH = 17;
   localparam int FIFO_DEPTH = 16;
   localparam int SDA_PIN_DEF = 0;
   localparam int SCL_PIN_DEF = 1;
   typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_NEXT, S_STOP} iwm_phase_t;
   typedef enum logic [2:0] {G_CTRL, G_ADDRH, G_ADDRL, G_DATA, G_END} iwm_stage_t;
endpackage

// >>> rtl/iwm_fifo_if.sv
/*
 Handshake bundle between the write master and its data queue.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface iwm_fifo_if;
   logic wr_valid;
   logic wr_ready;
   logic [iwm_pkg::FIFO_WIDTH-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [iwm_pkg::FIFO_WIDTH-1:0] rd_data;
   modport queue (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
   modport user (output wr_valid, output wr_data, output rd_ready,
                 input wr_ready, input rd_valid, input rd_data);
endinterface

// >>> rtl/iwm_fifo.sv
/*
 Flip-flop queue of data items with valid/ready on both sides.
 Assumes a power-of-two depth and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module iwm_fifo #(
   parameter int WIDTH = iwm_pkg::FIFO_WIDTH,
   parameter int DEPTH = iwm_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   iwm_fifo_if.queue q
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } iwm_fifo_state_t;

   iwm_fifo_state_t s;
   iwm_fifo_state_t next_s;
   logic push;
   logic pop;

   // handshake flags straight from the fill count
   assign q.wr_ready = (s.cnt != FULL_CNT);
   assign q.rd_valid = (s.cnt != '0);
   assign q.rd_data = s.mem[s.rp];

   // pointer and count update
   always_comb begin
      next_s = s;
      push = q.wr_valid && q.wr_ready;
      pop = q.rd_ready && q.rd_valid;
      if (push) begin
         next_s.mem[s.wp] = WIDTH'(q.wr_data);
         next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// >>> rtl/iwm_top.sv
/*
 Two-wire bus master write engine with register port and data queue.
 Assumes open-drain pins with external pull-ups and software that queues
 data items before or during a full write transfer.
*/
`timescale 1ns/1ps
module iwm_top #(
   parameter int SDA_PIN = iwm_pkg::SDA_PIN_DEF,
   parameter int SCL_PIN = iwm_pkg::SCL_PIN_DEF
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out_out,
   output logic [7:0] port_oe_n_out,
   output logic busy_out,
   output logic ack_result_out
);
   localparam int FIFO_W = iwm_pkg::FIFO_WIDTH;

   typedef struct packed {
      iwm_pkg::iwm_phase_t st;
      iwm_pkg::iwm_stage_t stage;
      logic [1:0] q;
      logic [4:0] cnt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic ack_send;
      logic sample;
      logic full;
      logic rd_dir;
      logic lo_pend;
      logic [7:0] lo_byte;
      logic [7:0] left;
      logic all;
      logic sda_rel;
      logic scl_rel;
      logic [7:0] ctrl_byte;
      logic [15:0] taddr;
      logic slow;
      logic [1:0] amode;
      logic ack;
      logic ovf;
      logic busy;
      logic [31:0] rdata;
      logic [7:0] oe_n;
      logic [7:0] pout;
      logic sda_s1;
      logic sda_s2;
      logic scl_s1;
      logic scl_s2;
   } iwm_state_t;

   iwm_state_t s;
   iwm_state_t next_s;
   logic cmd_wr;
   logic hold;
   logic qend;
   logic [4:0] qlen;
   logic [FIFO_W-1:0] item;

   iwm_fifo_if fq ();

   iwm_fifo #(
      .WIDTH(iwm_pkg::FIFO_WIDTH),
      .DEPTH(iwm_pkg::FIFO_DEPTH)
   ) u_queue (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .q(fq.queue)
   );

   // register address match
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // arm one byte for shifting, starting at bit 7
   function automatic iwm_state_t load_byte(input iwm_state_t x, input logic [7:0] b,
                                            input logic [4:0] len);
      iwm_state_t y;
      y = x;
      y.sh = b;
      y.bitn = '0;
      y.st = iwm_pkg::S_BIT;
      y.q = '0;
      y.cnt = len;
      load_byte = y;
   endfunction

   // begin a stop sequence
   function automatic iwm_state_t go_stop(input iwm_state_t x, input logic [4:0] len);
      iwm_state_t y;
      y = x;
      y.st = iwm_pkg::S_STOP;
      y.q = '0;
      y.cnt = len;
      go_stop = y;
   endfunction

   // queue push from the data register, pop driven by the sequencer
   assign fq.wr_valid = reg_wr_in && hit(reg_addr_in, iwm_pkg::REG_DATA);
   assign fq.wr_data = reg_wdata_in[FIFO_W-1:0];
   assign item = fq.rd_data;

   // quarter-period length and clock-stretch hold
   assign qlen = ((s.slow && iwm_pkg::SLOW_ALLOWED) ? iwm_pkg::SLOW_QUARTER_CYC :
                  iwm_pkg::FAST_QUARTER_CYC) - 5'h1;
   assign hold = s.scl_rel && !s.scl_s2;
   assign qend = (s.cnt == 5'h0) && !hold;
   assign cmd_wr = reg_wr_in && hit(reg_addr_in, iwm_pkg::REG_COMMAND);

   // next-state logic of the whole block
   always_comb begin
      next_s = s;
      fq.rd_ready = 1'b0;
      // two-stage synchronisers on the selected pins
      next_s.sda_s1 = port_in[SDA_PIN];
      next_s.sda_s2 = s.sda_s1;
      next_s.scl_s1 = port_in[SCL_PIN];
      next_s.scl_s2 = s.scl_s1;

      // register writes
      if (reg_wr_in) begin
         if (hit(reg_addr_in, iwm_pkg::REG_CTRL_BYTE)) begin
            next_s.ctrl_byte = reg_wdata_in[7:0];
         end
         if (hit(reg_addr_in, iwm_pkg::REG_TARGET_ADDR)) begin
            next_s.taddr = reg_wdata_in[15:0];
         end
         if (hit(reg_addr_in, iwm_pkg::REG_CONFIG)) begin
            next_s.slow = reg_wdata_in[iwm_pkg::CFG_SLOW_BIT];
            next_s.amode = reg_wdata_in[iwm_pkg::CFG_AMODE_LSB +: 2];
         end
         if (hit(reg_addr_in, iwm_pkg::REG_STATUS) && reg_wdata_in[iwm_pkg::ST_OVF_BIT]) begin
            next_s.ovf = 1'b0;
         end
      end
      // overflow set wins over its clear
      if (fq.wr_valid && !fq.wr_ready) begin
         next_s.ovf = 1'b1;
      end

      // read data stands for the cycle after the strobe only
      next_s.rdata = '0;
      if (reg_rd_in) begin
         if (hit(reg_addr_in, iwm_pkg::REG_CTRL_BYTE)) begin
            next_s.rdata = {24'h000000, s.ctrl_byte};
         end else if (hit(reg_addr_in, iwm_pkg::REG_TARGET_ADDR)) begin
            next_s.rdata = {16'h0000, s.taddr};
         end else if (hit(reg_addr_in, iwm_pkg::REG_CONFIG)) begin
            next_s.rdata = {29'h00000000, s.amode, s.slow};
         end else if (hit(reg_addr_in, iwm_pkg::REG_STATUS)) begin
            next_s.rdata = {27'h0000000, s.ovf, !fq.wr_ready, !fq.rd_valid, s.busy, s.ack};
         end else if (hit(reg_addr_in, iwm_pkg::REG_ACK_FLAG)) begin
            next_s.rdata = {31'h00000000, s.ack};
         end
      end

      // quarter-period timer, frozen while a released clock is held low
      if (s.st != iwm_pkg::S_IDLE) begin
         if (qend) begin
            next_s.cnt = qlen;
            next_s.q = s.q + 2'h1;
         end else if (!hold) begin
            next_s.cnt = s.cnt - 5'h1;
         end
      end

      case (s.st)
         iwm_pkg::S_IDLE: begin
            if (cmd_wr) begin
               next_s.cnt = qlen;
               next_s.q = '0;
               next_s.full = 1'b0;
               next_s.sample = 1'b1;
               next_s.ack_send = 1'b0;
               if (reg_wdata_in[iwm_pkg::CMD_FULL_BIT]) begin
                  // full transfer: start, then the sequencer takes over
                  next_s.full = 1'b1;
                  next_s.rd_dir = reg_wdata_in[iwm_pkg::CMD_READ_BIT];
                  next_s.stage = iwm_pkg::G_CTRL;
                  next_s.left = reg_wdata_in[iwm_pkg::CMD_ARG_LSB +: 8];
                  next_s.all = (reg_wdata_in[iwm_pkg::CMD_ARG_LSB +: 8] == 8'h00);
                  next_s.lo_pend = 1'b0;
                  next_s.ack = 1'b0;
                  next_s.st = iwm_pkg::S_START;
               end else if (reg_wdata_in[iwm_pkg::CMD_SINGLE_BIT]) begin
                  // lone byte with no start or stop around it
                  next_s = load_byte(next_s, reg_wdata_in[iwm_pkg::CMD_ARG_LSB +: 8], qlen);
               end else if (reg_wdata_in[iwm_pkg::CMD_START_BIT] ||
                            reg_wdata_in[iwm_pkg::CMD_RESTART_BIT]) begin
                  next_s.st = iwm_pkg::S_START;
               end else if (reg_wdata_in[iwm_pkg::CMD_STOP_BIT]) begin
                  next_s.st = iwm_pkg::S_STOP;
               end else if (reg_wdata_in[iwm_pkg::CMD_ACK_BIT]) begin
                  // master-driven acknowledge pulse
                  next_s = load_byte(next_s, 8'h00, qlen);
                  next_s.bitn = iwm_pkg::ACK_BIT_IDX;
                  next_s.ack_send = 1'b1;
                  next_s.sample = 1'b0;
               end
            end
         end
         iwm_pkg::S_START: begin
            // release data, release clock, data low, clock low
            if (s.q == 2'h0) begin
               next_s.sda_rel = 1'b1;
            end
            if (s.q == 2'h1) begin
               next_s.scl_rel = 1'b1;
            end
            if (s.q == 2'h2) begin
               next_s.sda_rel = 1'b0;
            end
            if (s.q == 2'h3) begin
               next_s.scl_rel = 1'b0;
               if (qend) begin
                  next_s.st = s.full ? iwm_pkg::S_NEXT : iwm_pkg::S_IDLE;
               end
            end
         end
         iwm_pkg::S_BIT: begin
            // clock low in quarters 0-1, high in 2-3
            next_s.scl_rel = s.q[1];
            if (s.q == 2'h1) begin
               // data moves only in the middle of the low half
               if (s.bitn == iwm_pkg::ACK_BIT_IDX) begin
                  next_s.sda_rel = !s.ack_send;
               end else begin
                  next_s.sda_rel = s.sh[7];
               end
            end
            if (s.q == 2'h3 && qend) begin
               next_s.scl_rel = 1'b0;
               if (s.bitn == iwm_pkg::ACK_BIT_IDX) begin
                  if (s.sample) begin
                     next_s.ack = s.sda_s2;
                  end
                  next_s.st = s.full ? iwm_pkg::S_NEXT : iwm_pkg::S_IDLE;
               end else begin
                  next_s.bitn = s.bitn + 4'h1;
                  next_s.sh = {s.sh[6:0], 1'b0};
               end
            end
         end
         iwm_pkg::S_NEXT: begin
            next_s.scl_rel = 1'b0;
            if (s.ack) begin
               // refused byte ends the transfer
               next_s = go_stop(next_s, qlen);
            end else begin
               case (s.stage)
                  iwm_pkg::G_CTRL: begin
                     next_s = load_byte(next_s, {s.ctrl_byte[7:1], s.rd_dir}, qlen);
                     if (s.rd_dir || s.amode == iwm_pkg::AMODE_NONE) begin
                        next_s.stage = s.rd_dir ? iwm_pkg::G_END : iwm_pkg::G_DATA;
                     end else if (s.amode == iwm_pkg::AMODE_WORD) begin
                        next_s.stage = iwm_pkg::G_ADDRH;
                     end else begin
                        next_s.stage = iwm_pkg::G_ADDRL;
                     end
                  end
                  iwm_pkg::G_ADDRH: begin
                     next_s = load_byte(next_s, s.taddr[15:8], qlen);
                     next_s.stage = iwm_pkg::G_ADDRL;
                  end
                  iwm_pkg::G_ADDRL: begin
                     next_s = load_byte(next_s, s.taddr[7:0], qlen);
                     next_s.stage = iwm_pkg::G_DATA;
                  end
                  iwm_pkg::G_DATA: begin
                     if (s.lo_pend) begin
                        next_s = load_byte(next_s, s.lo_byte, qlen);
                        next_s.lo_pend = 1'b0;
                     end else if (!s.all && s.left == 8'h00) begin
                        next_s = go_stop(next_s, qlen);
                     end else if (fq.rd_valid) begin
                        // items leave the queue in the order written
                        fq.rd_ready = 1'b1;
                        next_s.left = s.left - 8'h01;
                        if (item[iwm_pkg::DATA_WORD_BIT]) begin
                           next_s = load_byte(next_s, item[15:8], qlen);
                           next_s.lo_pend = 1'b1;
                           next_s.lo_byte = item[7:0];
                        end else begin
                           next_s = load_byte(next_s, item[7:0], qlen);
                        end
                     end else if (s.all) begin
                        next_s = go_stop(next_s, qlen);
                     end
                  end
                  default: begin
                     next_s = go_stop(next_s, qlen);
                  end
               endcase
            end
         end
         iwm_pkg::S_STOP: begin
            // data low, release clock, release data
            if (s.q == 2'h0) begin
               next_s.sda_rel = 1'b0;
            end
            if (s.q == 2'h1) begin
               next_s.scl_rel = 1'b1;
            end
            if (s.q == 2'h2) begin
               next_s.sda_rel = 1'b1;
            end
            if (s.q == 2'h3 && qend) begin
               next_s.st = iwm_pkg::S_IDLE;
               next_s.full = 1'b0;
            end
         end
         default: begin
            next_s.st = iwm_pkg::S_IDLE;
         end
      endcase

      // open-drain pin enables, low only where a line is pulled down
      for (int i = 0; i < 8; i++) begin
         next_s.oe_n[i] = 1'b1;
         if (i == SDA_PIN) begin
            next_s.oe_n[i] = next_s.sda_rel;
         end
         if (i == SCL_PIN) begin
            next_s.oe_n[i] = next_s.scl_rel;
         end
      end
      next_s.busy = (next_s.st != iwm_pkg::S_IDLE);
   end

   // state register
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         s <= '0;
         s.ctrl_byte <= iwm_pkg::CTRL_BYTE_RST;
         s.taddr <= iwm_pkg::TARGET_ADDR_RST;
         s.amode <= iwm_pkg::AMODE_NONE;
         s.sda_rel <= 1'b1;
         s.scl_rel <= 1'b1;
         s.oe_n <= 8'hFF;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign reg_rdata_out = s.rdata;
   assign port_out_out = s.pout;
   assign port_oe_n_out = s.oe_n;
   assign busy_out = s.busy;
   assign ack_result_out = s.ack;
endmodule

// >>> testbench/iwm_top_assertions.sv
/*
 Checker of the two-wire write master, watching only the top ports.
 Assumes open-drain pins released high and the register map of the package.
*/
`timescale 1ns/1ps
module iwm_checker #(
   parameter int SDA_PIN = 0,
   parameter int SCL_PIN = 1
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [7:0] port_in,
   input wire logic [7:0] port_out_out,
   input wire logic [7:0] port_oe_n_out,
   input wire logic busy_out,
   input wire logic ack_result_out
);
   localparam logic [7:0] USED = (8'h01 << SDA_PIN) | (8'h01 << SCL_PIN);
   // clock pin released by the master
   wire logic scl_rel = port_oe_n_out[SCL_PIN];
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   // pins only ever pulled low or released
   out_low_a: assert property (port_out_out == 8'h00)
      else $error("pin data not low");
   spare_pins_a: assert property ((port_oe_n_out | USED) == 8'hFF)
      else $error("unused pin driven");
   busy_start_a: assert property (!busy_out && reg_wr_in && reg_addr_in == iwm_pkg::REG_COMMAND
      && reg_wdata_in[1:0] != 2'h0 |=> busy_out) else $error("busy missing after command");
   ack_mirror_a: assert property (reg_rd_in && reg_addr_in == iwm_pkg::REG_ACK_FLAG
      |=> reg_rdata_out == {31'h0, $past(ack_result_out)}) else $error("ack flag differs");
   status_busy_a: assert property (reg_rd_in && reg_addr_in == iwm_pkg::REG_STATUS
      |=> reg_rdata_out[1:0] == {$past(busy_out), $past(ack_result_out)}) else $error("status differs");
   quiet_idle_a: assert property (!busy_out && !$past(busy_out) && !$past(busy_out, 2)
      |-> $stable(port_oe_n_out)) else $error("pins move while idle");
   clk_high_a: assert property ($rose(scl_rel) |-> scl_rel [*8])
      else $error("bus clock high too short");
   clk_low_a: assert property ($fell(scl_rel) |-> !scl_rel [*8])
      else $error("bus clock low too short");
   reset_state_a: assert property ($rose(reset_n_in) |-> port_oe_n_out == 8'hFF && !busy_out)
      else $error("lines not released after reset");
   // main scenarios reached
   cover property (busy_out && $past(!busy_out));
   cover property ($rose(ack_result_out));
   cover property ($fell(busy_out));
endmodule
bind iwm_top iwm_checker #(.SDA_PIN(SDA_PIN), .SCL_PIN(SCL_PIN)) u_chk (.clk_sys_in, .reset_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .port_in, .port_out_out,
   .port_oe_n_out, .busy_out, .ack_result_out);

// >>> testbench/iwm_target_model.sv
/*
 Behavioural addressed target that collects the bytes of the bus.
 Assumes pull-ups on both lines; the bench resolves the wires.
*/
`timescale 1ns/1ps
module iwm_target_model (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic nack_in,
   output logic pull_out
);
   logic [7:0] shift;
   logic ack_phase = 1'b0;
   int n_bits = 0;
   int starts = 0;
   int stops = 0;
   logic [7:0] got[$];
   initial pull_out = 1'b0;
   // start or restart: data falls while clock high
   always @(negedge sda_in) begin
      if (scl_in === 1'b1) begin
         starts++;
         n_bits = 0;
         ack_phase = 1'b0;
      end
   end
   // stop: data rises while clock high
   always @(posedge sda_in) begin
      if (scl_in === 1'b1) stops++;
   end
   // bits taken msb first, ninth pulse belongs to the acknowledge
   always @(posedge scl_in) begin
      if (ack_phase) n_bits = 0;
      else if (n_bits < 8) begin
         shift = {shift[6:0], sda_in};
         n_bits++;
      end
   end
   // pull data low over the ninth pulse unless told to refuse
   always @(negedge scl_in) begin
      if (ack_phase) begin
         ack_phase = 1'b0;
         pull_out = 1'b0;
      end else if (n_bits == 8) begin
         got.push_back(shift);
         ack_phase = 1'b1;
         pull_out = !nack_in;
      end
   end
endmodule

// >>> testbench/iwm_top_tb.sv
/*
 Self-checking bench of the write master with a target model.
 Assumes a 10 MHz clock and pull-ups on data and clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t: %0h not %0h", $time, a, b); end end
module iwm_top_tb;
   logic clk_sys_in;
   logic reset_n_in;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [31:0] reg_rdata_out;
   logic [7:0] port_out_out;
   logic [7:0] port_oe_n_out;
   logic busy_out;
   logic ack_result_out;
   logic nack;
   logic pull;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   // open-drain lines with pull-ups
   wire logic scl = port_oe_n_out[1];
   wire logic sda = port_oe_n_out[0] & ~pull;
   iwm_top u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .port_in({6'h3F, scl, sda}), .port_out_out(port_out_out),
      .port_oe_n_out(port_oe_n_out), .busy_out(busy_out), .ack_result_out(ack_result_out));
   iwm_target_model u_tgt (.scl_in(scl), .sda_in(sda), .nack_in(nack), .pull_out(pull));
   task automatic give_verdict;
      if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 `CHK(reg_rdata_out, e)
      @(posedge clk_sys_in);
   endtask
   // issue a command and wait for the engine to go idle
   task automatic run(input logic [31:0] d);
      wr(iwm_pkg::REG_COMMAND, d);
      #1;
      while (busy_out !== 1'b0) begin
         @(posedge clk_sys_in);
         #1;
      end
      @(posedge clk_sys_in);
   endtask
   task automatic bytes(input logic [7:0] e[$], input int st, input int sp);
      `CHK(u_tgt.got.size(), e.size())
      foreach (e[i]) if (i < u_tgt.got.size()) `CHK(u_tgt.got[i], e[i])
      `CHK(u_tgt.starts, st)
      `CHK(u_tgt.stops, sp)
      u_tgt.got.delete();
      u_tgt.starts = 0;
      u_tgt.stops = 0;
   endtask
   task automatic t_full;
      wr(iwm_pkg::REG_CTRL_BYTE, 32'h000000A1);
      wr(iwm_pkg::REG_TARGET_ADDR, 32'h00001234);
      wr(iwm_pkg::REG_CONFIG, 32'h00000004);
      wr(iwm_pkg::REG_DATA, 32'h0001BEEF);
      wr(iwm_pkg::REG_DATA, 32'h00000041);
      wr(iwm_pkg::REG_DATA, 32'h00000001);
      run(32'h00000001);
      bytes('{8'hA0, 8'h12, 8'h34, 8'hBE, 8'hEF, 8'h41, 8'h01}, 1, 1);
      `CHK(ack_result_out, 1'b0)
   endtask
   task automatic t_count;
      wr(iwm_pkg::REG_CONFIG, 32'h00000002);
      wr(iwm_pkg::REG_DATA, 32'h00000055);
      wr(iwm_pkg::REG_DATA, 32'h00000066);
      run(32'h00000101);
      bytes('{8'hA0, 8'h34, 8'h55}, 1, 1);
      wr(iwm_pkg::REG_CONFIG, 32'h00000000);
      run(32'h00000001);
      bytes('{8'hA0, 8'h66}, 1, 1);
      wr(iwm_pkg::REG_CTRL_BYTE, 32'h000000A0);
      run(32'h00000041);
      bytes('{8'hA1}, 1, 1);
   endtask
   task automatic t_single;
      int t0;
      wr(iwm_pkg::REG_CONFIG, 32'h00000001);
      nack <= 1'b1;
      run(32'h00000004);
      t0 = cycles;
      run(32'h00005A02);
      `CHK(cycles - t0 > 800, 1'b1)
      `CHK(ack_result_out, 1'b1)
      rd(iwm_pkg::REG_ACK_FLAG, 32'h00000001);
      run(32'h00000008);
      nack <= 1'b0;
      run(32'h0000C302);
      `CHK(ack_result_out, 1'b0)
      run(32'h00000020);
      run(32'h00000010);
      bytes('{8'h5A, 8'hC3}, 2, 1);
   endtask
   task automatic t_nack_fill;
      int t0;
      int i;
      logic [7:0] e[$];
      wr(iwm_pkg::REG_CONFIG, 32'h00000000);
      nack <= 1'b1;
      t0 = cycles;
      run(32'h00000001);
      `CHK(cycles - t0 < 500, 1'b1)
      bytes('{8'hA0}, 1, 1);
      nack <= 1'b0;
      e = '{8'hA0};
      for (i = 0; i < 17; i++) begin
         wr(iwm_pkg::REG_DATA, 32'h00000010 + i);
         if (i < 16) e.push_back(8'(8'h10 + i));
      end
      rd(iwm_pkg::REG_STATUS, 32'h00000019);
      wr(iwm_pkg::REG_STATUS, 32'h00000010);
      rd(iwm_pkg::REG_STATUS, 32'h00000009);
      run(32'h00000001);
      bytes(e, 1, 1);
      rd(iwm_pkg::REG_STATUS, 32'h00000004);
   endtask
   // free-running system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   // hang guard
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      reset_n_in <= 1'b0;
      reg_addr_in <= 8'h00;
      reg_wdata_in <= 32'h00000000;
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      nack <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      // lines leaving the unknown level at reset look like edges to the target model
      u_tgt.starts = 0;
      u_tgt.stops = 0;
      `CHK(port_oe_n_out, 8'hFF)
      rd(iwm_pkg::REG_STATUS, 32'h00000004);
      wr(8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h00000000);
      t_full();
      t_count();
      t_single();
      t_nack_fill();
      give_verdict();
   end
endmodule
